// [usb_node_ctrl.sv]
// Control and diagnostic registers of the USB device node.
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`include "usb_node_map.svh"

module usb_node_ctrl
	import usb_node_pkg::*;
(
	input  wire logic        I_REF_CLK,
	input  wire logic        I_RST,
	input  wire logic [31:0] I_ADDR,
	input  wire logic [15:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [15:0] O_RDATA,
	input  wire logic        I_DP_LEVEL,
	input  wire logic        I_DM_LEVEL,
	input  wire logic        I_DIFF_LEVEL,
	input  wire logic [1:0]  I_NODE_STATE,
	input  wire logic        I_ENG_DP,
	input  wire logic        I_ENG_DM,
	input  wire logic        I_ENG_OE_N,
	output logic             O_DP,
	output logic             O_DM,
	output logic             O_DP_OE_N,
	output logic             O_DM_OE_N,
	output logic             O_DP_PULLUP,
	output logic             O_DM_PULLUP,
	output logic             O_NODE_CLK_EN,
	output logic             O_LOW_SPEED,
	output logic             O_NODE_LOCKED,
	output logic             O_EVENT_WR_EN,
	output logic             O_CRC_SUPPRESS,
	output logic             O_SHORT_FRAME,
	output logic      [2:0]  O_RX_THRESH,
	output logic      [4:0]  O_TX_EDGE_CUR
);

	reg_sel_t    reg_sel;
	line_mode_t  line_mode;
	logic        node_enable_q;
	logic        node_attached_q;
	logic        debug_lock_mode_q;
	logic        low_speed_select_q;
	logic        diag_test_enable_q;
	logic        diag_drive_enable_q;
	logic        neg_line_force_high_q;
	logic        pos_line_force_high_q;
	logic [2:0]  rx_threshold_trim_q;
	logic [4:0]  tx_edge_current_trim_q;
	logic        transceiver_access_enable_q;
	logic        crc_suppress_q;
	logic        short_frame_tracking_q;
	logic [4:0]  level_sync;
	logic        pos_line_level;
	logic        neg_line_level;
	logic        diff_comparator_level;
	logic [1:0]  node_state_sync;
	logic        diag_active;
	logic        diag_override;
	logic        wr_mctrl;
	logic        wr_xcv;
	logic        wr_trim;
	logic        wr_test;
	logic [15:0] rdata_d;
	logic [15:0] rdata_q;
	logic        dp_pullup_q;
	logic        dm_pullup_q;
	logic [2:0]  rx_thresh_q;
	logic [4:0]  tx_edge_q;

	////////////////////////////////////////////////////////////////////////////////
	// Pin level synchronisers.

	usb_line_sync #(
		.WIDTH (5)
	) u_level_sync (
		.i_clk   (I_REF_CLK),
		.i_rst   (I_RST),
		.i_async ({I_NODE_STATE, I_DIFF_LEVEL, I_DM_LEVEL, I_DP_LEVEL}),
		.o_sync  (level_sync)
	);

	assign pos_line_level        = level_sync[0];
	assign neg_line_level        = level_sync[1];
	assign diff_comparator_level = level_sync[2];
	assign node_state_sync       = level_sync[4:3];

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.

	always_comb begin
		if (I_ADDR == `NODE_MAIN_CONTROL_ADDR) begin
			reg_sel = SEL_MCTRL;
		end else if (I_ADDR == `TRANSCEIVER_DIAGNOSTIC_ADDR) begin
			reg_sel = SEL_XCVDIAG;
		end else if (I_ADDR == `TRANSCEIVER_TRIM_ADDR) begin
			reg_sel = SEL_TRIM;
		end else if (I_ADDR == `NODE_TEST_CONTROL_ADDR) begin
			reg_sel = SEL_TEST;
		end else begin
			reg_sel = SEL_NONE;
		end
	end

	assign wr_mctrl = I_WR && (reg_sel == SEL_MCTRL);
	assign wr_xcv   = I_WR && (reg_sel == SEL_XCVDIAG) && transceiver_access_enable_q;
	assign wr_trim  = I_WR && (reg_sel == SEL_TRIM) && transceiver_access_enable_q;
	assign wr_test  = I_WR && (reg_sel == SEL_TEST);

	////////////////////////////////////////////////////////////////////////////////
	// Main control register.

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			node_enable_q <= 1'b0;
		end else if (wr_mctrl) begin
			node_enable_q <= I_WDATA[`MCTRL_ENABLE_BIT];
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST || !node_enable_q) begin
			node_attached_q <= 1'b0;
		end else if (wr_mctrl) begin
			node_attached_q <= I_WDATA[`MCTRL_ATTACH_BIT] && I_WDATA[`MCTRL_ENABLE_BIT];
		end
	end

	// Debug lock opens write paths elsewhere and the node state readback; clear-on-read stays untouched.
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST || !node_enable_q) begin
			debug_lock_mode_q <= 1'b0;
		end else if (wr_mctrl) begin
			debug_lock_mode_q <= I_WDATA[`MCTRL_DEBUG_BIT] && I_WDATA[`MCTRL_ENABLE_BIT];
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			low_speed_select_q <= 1'b0;
		end else if (wr_mctrl && !node_enable_q) begin
			low_speed_select_q <= I_WDATA[`MCTRL_LOWSPD_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transceiver diagnostic register.

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST || !node_enable_q) begin
			diag_test_enable_q    <= 1'b0;
			diag_drive_enable_q   <= 1'b0;
			neg_line_force_high_q <= 1'b0;
			pos_line_force_high_q <= 1'b0;
		end else if (wr_xcv) begin
			diag_test_enable_q    <= I_WDATA[`XCV_TEST_BIT];
			diag_drive_enable_q   <= I_WDATA[`XCV_DRIVE_BIT];
			neg_line_force_high_q <= I_WDATA[`XCV_NEG_FORCE_BIT];
			pos_line_force_high_q <= I_WDATA[`XCV_POS_FORCE_BIT];
		end
	end

	assign diag_active   = transceiver_access_enable_q && diag_test_enable_q;
	assign diag_override = diag_active && diag_drive_enable_q;

	////////////////////////////////////////////////////////////////////////////////
	// Transceiver trim register, kept while the node is disabled.

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			rx_threshold_trim_q    <= `TRIM_THRESH_RST;
			tx_edge_current_trim_q <= `TRIM_EDGE_RST;
		end else if (wr_trim) begin
			rx_threshold_trim_q    <= I_WDATA[`TRIM_THRESH_MSB:`TRIM_THRESH_LSB];
			tx_edge_current_trim_q <= I_WDATA[`TRIM_EDGE_MSB:`TRIM_EDGE_LSB];
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			rx_thresh_q <= `TRIM_THRESH_RST;
			tx_edge_q   <= `TRIM_EDGE_RST;
		end else if (transceiver_access_enable_q) begin
			rx_thresh_q <= rx_threshold_trim_q;
			tx_edge_q   <= tx_edge_current_trim_q;
		end else begin
			rx_thresh_q <= `TRIM_THRESH_RST;
			tx_edge_q   <= `TRIM_EDGE_RST;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Test control register; the reserved field is never stored.

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST || !node_enable_q) begin
			transceiver_access_enable_q <= 1'b0;
			crc_suppress_q              <= 1'b0;
			short_frame_tracking_q      <= 1'b0;
		end else if (wr_test) begin
			transceiver_access_enable_q <= I_WDATA[`UTR_ACCESS_BIT];
			crc_suppress_q              <= I_WDATA[`UTR_NOCRC_BIT];
			short_frame_tracking_q      <= I_WDATA[`UTR_SHORT_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Line drive and pull-ups.

	always_comb begin
		if (diag_override) begin
			line_mode = LINE_DIAG;
		end else if (!node_enable_q || !node_attached_q) begin
			line_mode = LINE_SE0;
		end else begin
			line_mode = LINE_ENGINE;
		end
	end

	usb_line_drive u_line_drive (
		.i_clk       (I_REF_CLK),
		.i_rst       (I_RST),
		.i_mode      (line_mode),
		.i_pos_force (pos_line_force_high_q),
		.i_neg_force (neg_line_force_high_q),
		.i_eng_dp    (I_ENG_DP),
		.i_eng_dm    (I_ENG_DM),
		.i_eng_oe_n  (I_ENG_OE_N),
		.o_dp        (O_DP),
		.o_dm        (O_DM),
		.o_dp_oe_n   (O_DP_OE_N),
		.o_dm_oe_n   (O_DM_OE_N)
	);

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			dp_pullup_q <= 1'b0;
			dm_pullup_q <= 1'b0;
		end else begin
			dp_pullup_q <= node_attached_q && !low_speed_select_q;
			dm_pullup_q <= node_attached_q && low_speed_select_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path.

	always_comb begin
		rdata_d = `REG_RESET_VALUE;
		if (reg_sel == SEL_MCTRL) begin
			rdata_d[`MCTRL_ENABLE_BIT] = node_enable_q;
			rdata_d[`MCTRL_DEBUG_BIT]  = debug_lock_mode_q;
			rdata_d[`MCTRL_ATTACH_BIT] = node_attached_q;
			rdata_d[`MCTRL_LOWSPD_BIT] = low_speed_select_q;
		end else if (reg_sel == SEL_XCVDIAG && transceiver_access_enable_q) begin
			rdata_d[`XCV_POS_LVL_BIT]   = diag_active && pos_line_level;
			rdata_d[`XCV_NEG_LVL_BIT]   = diag_active && neg_line_level;
			rdata_d[`XCV_COMP_BIT]      = diag_active && diff_comparator_level;
			rdata_d[`XCV_DRIVE_BIT]     = diag_drive_enable_q;
			rdata_d[`XCV_NEG_FORCE_BIT] = neg_line_force_high_q;
			rdata_d[`XCV_POS_FORCE_BIT] = pos_line_force_high_q;
			rdata_d[`XCV_TEST_BIT]      = diag_test_enable_q;
			if (debug_lock_mode_q && diag_active) begin
				rdata_d[`XCV_STATE_MSB:`XCV_STATE_LSB] = node_state_sync;
			end
		end else if (reg_sel == SEL_TRIM && transceiver_access_enable_q) begin
			rdata_d[`TRIM_THRESH_MSB:`TRIM_THRESH_LSB] = rx_threshold_trim_q;
			rdata_d[`TRIM_EDGE_MSB:`TRIM_EDGE_LSB]     = tx_edge_current_trim_q;
		end else if (reg_sel == SEL_TEST) begin
			rdata_d[`UTR_ACCESS_BIT] = transceiver_access_enable_q;
			rdata_d[`UTR_NOCRC_BIT]  = crc_suppress_q;
			rdata_d[`UTR_SHORT_BIT]  = short_frame_tracking_q;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			rdata_q <= `REG_RESET_VALUE;
		end else if (I_RD) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= `REG_RESET_VALUE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign O_RDATA        = rdata_q;
	assign O_NODE_CLK_EN  = node_enable_q;
	assign O_LOW_SPEED    = low_speed_select_q;
	assign O_NODE_LOCKED  = debug_lock_mode_q;
	assign O_EVENT_WR_EN  = debug_lock_mode_q;
	assign O_CRC_SUPPRESS = crc_suppress_q;
	assign O_SHORT_FRAME  = short_frame_tracking_q;
	assign O_DP_PULLUP    = dp_pullup_q;
	assign O_DM_PULLUP    = dm_pullup_q;
	assign O_RX_THRESH    = rx_thresh_q;
	assign O_TX_EDGE_CUR  = tx_edge_q;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	a_attach_needs_enable: assert property (
		@(posedge I_REF_CLK) disable iff (I_RST)
		(node_attached_q || debug_lock_mode_q) |-> node_enable_q
	) else $error("Attach or debug set while node disabled.");

	a_disable_clears_attach: assert property (
		@(posedge I_REF_CLK) disable iff (I_RST)
		(wr_mctrl && !I_WDATA[`MCTRL_ENABLE_BIT]) |=> !node_attached_q && !node_enable_q
	) else $error("Attach survived a disable.");

	a_detached_drives_se0: assert property (
		@(posedge I_REF_CLK) disable iff (I_RST)
		(!node_attached_q && !diag_override) |=> (!O_DP && !O_DM && !O_DP_OE_N && !O_DM_OE_N)
	) else $error("Lines not in SE0 while detached.");

	a_attached_releases: assert property (
		@(posedge I_REF_CLK) disable iff (I_RST)
		(node_attached_q && !diag_override) |=> (O_DP_OE_N == $past(I_ENG_OE_N))
	) else $error("Attached node does not hand lines to engine.");

	a_speed_locked: assert property (
		@(posedge I_REF_CLK) disable iff (I_RST)
		node_enable_q ##1 node_enable_q |-> $stable(low_speed_select_q)
	) else $error("Speed changed while enabled.");

	a_pullup_swap: assert property (
		@(posedge I_REF_CLK) disable iff (I_RST)
		node_attached_q ##1 node_attached_q |-> (O_DM_PULLUP == low_speed_select_q) && (O_DP_PULLUP != O_DM_PULLUP)
	) else $error("Pull-up not on the line for the speed.");

	a_diag_force_lines: assert property (
		@(posedge I_REF_CLK) disable iff (I_RST)
		diag_override |=> (O_DM == $past(neg_line_force_high_q)) && (O_DP == $past(pos_line_force_high_q))
	) else $error("Diagnostic override not on the lines.");

	a_diag_levels_zero: assert property (
		@(posedge I_REF_CLK) disable iff (I_RST)
		(I_RD && reg_sel == SEL_XCVDIAG && !diag_test_enable_q) |=> (O_RDATA[7:5] == 3'h0)
	) else $error("Line levels visible with test disabled.");

	a_trim_gated: assert property (
		@(posedge I_REF_CLK) disable iff (I_RST)
		!transceiver_access_enable_q |=> (O_RX_THRESH == 3'h4) && (O_TX_EDGE_CUR == 5'h10)
	) else $error("Trim applied without diagnostic access.");

	a_nocrc_write: assert property (
		@(posedge I_REF_CLK) disable iff (I_RST)
		(wr_test && node_enable_q) |=> (O_CRC_SUPPRESS == $past(I_WDATA[6]))
	) else $error("CRC suppress does not follow write.");

	a_read_one_cycle: assert property (
		@(posedge I_REF_CLK) disable iff (I_RST)
		!I_RD |=> (O_RDATA == 16'h0000)
	) else $error("Read data present outside read answer cycle.");

	a_mctrl_readback: assert property (
		@(posedge I_REF_CLK) disable iff (I_RST)
		(I_RD && reg_sel == SEL_MCTRL) |=> (O_RDATA[15:5] == 11'h000) && (O_RDATA[0] == $past(node_enable_q))
	) else $error("Main control readback wrong.");

	c_attach: cover property (@(posedge I_REF_CLK) disable iff (I_RST) $rose(node_attached_q));
	c_debug_lock: cover property (@(posedge I_REF_CLK) disable iff (I_RST) $rose(debug_lock_mode_q));
	c_diag_drive: cover property (@(posedge I_REF_CLK) disable iff (I_RST) diag_override ##1 !O_DP_OE_N);
	c_low_speed: cover property (@(posedge I_REF_CLK) disable iff (I_RST) node_attached_q && low_speed_select_q);

endmodule

// [usb_node_map.svh]
// Offsets, field positions and reset values of the USB node control registers.
//
// Functional notes
// - Low speed select runs the node at 1.5 Mbit/s and swaps the pull-up line.
// - While node attached is 0 and no diagnostic override is on, the transceiver drives SE0 on both lines.
// - Node attached is 0 after reset and whenever the node is disabled.
// - With node attached at 1 the node releases the lines for hub reset signalling.
// - Node attached and debug lock mode accept a 1 only while node enable is 1.
// - Debug lock mode makes the event, transmit and receive status registers writable.
// - Debug lock mode locks the node; with test enable at 1 node state is readable through the diagnostic register.
// - Clear-on-read bits keep clearing on read while debug lock mode is set.
// - Node enable is bit 0 of the main control register and resets to 0.
// - With node enable at 0 the node is off and its 48 MHz clock stops.
// - With node enable at 0 registers other than low speed select and trim hold reset values and the lines carry SE0.
// - With test enable at 1 bits 7, 6, 5 show D+, D- and comparator levels.
// - Diagnostic drive enable bit 3 with test bit 0 enables override bits 2 and 1.
// - With bits 3 and 0 set, bit 2 drives D- high, bit 1 drives D+ high.
// - Test enable bit 0 gates all diagnostic test bits 7, 6, 5, 3, 2 and 1.
// - Threshold trim bits 7:5 reset to 0x4 and act only with diagnostic access set.
// - Edge current trim bits 4:0 reset to 0x10 and act only with diagnostic access set.
// - Diagnostic access bit 7 opens the diagnostic and trim registers.
// - CRC suppress bit 6 drops the trailing CRC16 of transmitted packets only.
// - Short frame bit 5 lets the frame timer track short frames; normally clear.
`ifndef USB_NODE_MAP_SVH
`define USB_NODE_MAP_SVH

`define NODE_MAIN_CONTROL_ADDR      32'h5000_1800
`define TRANSCEIVER_DIAGNOSTIC_ADDR 32'h5000_1802
`define TRANSCEIVER_TRIM_ADDR       32'h5000_1804
`define NODE_TEST_CONTROL_ADDR      32'h5000_1806

`define MCTRL_ENABLE_BIT  0
`define MCTRL_DEBUG_BIT   1
`define MCTRL_ATTACH_BIT  3
`define MCTRL_LOWSPD_BIT  4

`define XCV_TEST_BIT      0
`define XCV_POS_FORCE_BIT 1
`define XCV_NEG_FORCE_BIT 2
`define XCV_DRIVE_BIT     3
`define XCV_COMP_BIT      5
`define XCV_NEG_LVL_BIT   6
`define XCV_POS_LVL_BIT   7
`define XCV_STATE_LSB     8
`define XCV_STATE_MSB     9

`define TRIM_THRESH_LSB   5
`define TRIM_THRESH_MSB   7
`define TRIM_EDGE_LSB     0
`define TRIM_EDGE_MSB     4
`define TRIM_THRESH_RST   3'h4
`define TRIM_EDGE_RST     5'h10

`define UTR_SHORT_BIT     5
`define UTR_NOCRC_BIT     6
`define UTR_ACCESS_BIT    7

`define LOW_SPEED_RATE_KBPS 1500
`define REG_RESET_VALUE     16'h0000

`endif

// [usb_node_pkg.sv]
// Types shared by the USB node control logic.
package usb_node_pkg;

	typedef enum logic [2:0] {
		SEL_NONE    = 3'b000,
		SEL_MCTRL   = 3'b001,
		SEL_XCVDIAG = 3'b010,
		SEL_TRIM    = 3'b011,
		SEL_TEST    = 3'b100
	} reg_sel_t;

	typedef enum logic [1:0] {
		LINE_SE0    = 2'b00,
		LINE_DIAG   = 2'b01,
		LINE_ENGINE = 2'b10
	} line_mode_t;

endpackage

// [usb_line_sync.sv]
// Two flip-flop synchroniser for pin levels.
`timescale 1ns/100ps

module usb_line_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule

// [usb_line_drive.sv]
// Registered driver for the D+ and D- pins.
`timescale 1ns/100ps

module usb_line_drive
	import usb_node_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire line_mode_t i_mode,
	input  wire logic       i_pos_force,
	input  wire logic       i_neg_force,
	input  wire logic       i_eng_dp,
	input  wire logic       i_eng_dm,
	input  wire logic       i_eng_oe_n,
	output logic            o_dp,
	output logic            o_dm,
	output logic            o_dp_oe_n,
	output logic            o_dm_oe_n
);

	// Output enables are active low; SE0 is both lines driven low.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_dp      <= 1'b0;
			o_dm      <= 1'b0;
			o_dp_oe_n <= 1'b0;
			o_dm_oe_n <= 1'b0;
		end else begin
			case (i_mode)
				LINE_DIAG: begin
					o_dp      <= i_pos_force;
					o_dm      <= i_neg_force;
					o_dp_oe_n <= 1'b0;
					o_dm_oe_n <= 1'b0;
				end
				LINE_ENGINE: begin
					o_dp      <= i_eng_dp;
					o_dm      <= i_eng_dm;
					o_dp_oe_n <= i_eng_oe_n;
					o_dm_oe_n <= i_eng_oe_n;
				end
				default: begin
					o_dp      <= 1'b0;
					o_dm      <= 1'b0;
					o_dp_oe_n <= 1'b0;
					o_dm_oe_n <= 1'b0;
				end
			endcase
		end
	end

endmodule

// [usb_hub_model.sv]
// Behavioural hub on the far side of the USB lines.
`timescale 1ns/100ps

module usb_hub_model #(
	parameter int LAG_NS = 0
) (
	input  wire logic i_dp,
	input  wire logic i_dm,
	input  wire logic i_dp_oe_n,
	input  wire logic i_dm_oe_n,
	input  wire logic i_dp_pullup,
	input  wire logic i_dm_pullup,
	input  wire logic i_bus_reset,
	output logic      o_dp_level,
	output logic      o_dm_level,
	output logic      o_diff_level
);

	logic dp_w;
	logic dm_w;

	////////////////////////////////////////////////////////////////////////////////
	// A driven line wins unless hub reset makes it x, else hub reset drives SE0, else pull-up against the hub pull-down.
	always_comb begin
		if (!i_dp_oe_n) begin
			dp_w = i_bus_reset ? 1'bx : i_dp;
		end else if (i_bus_reset) begin
			dp_w = 1'b0;
		end else begin
			dp_w = i_dp_pullup;
		end
		if (!i_dm_oe_n) begin
			dm_w = i_bus_reset ? 1'bx : i_dm;
		end else if (i_bus_reset) begin
			dm_w = 1'b0;
		end else begin
			dm_w = i_dm_pullup;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive levels reach the node after the line delay.
	assign #(LAG_NS) o_dp_level   = dp_w;
	assign #(LAG_NS) o_dm_level   = dm_w;
	assign #(LAG_NS) o_diff_level = dp_w & ~dm_w;

endmodule

// [usb_node_ctrl_diag_tb.sv]
// Self-checking testbench of the USB node control and diagnostic registers.
`timescale 1ns/100ps
`include "usb_node_map.svh"

module usb_node_control_diag_tb
	import usb_node_pkg::*;
;

	localparam logic [31:0] A_MC = `NODE_MAIN_CONTROL_ADDR;
	localparam logic [31:0] A_DG = `TRANSCEIVER_DIAGNOSTIC_ADDR;
	localparam logic [31:0] A_TR = `TRANSCEIVER_TRIM_ADDR;
	localparam logic [31:0] A_TS = `NODE_TEST_CONTROL_ADDR;

	logic        ref_clk, rst, wr_stb, rd_stb, dp_lvl, dm_lvl, diff_lvl, eng_dp, eng_dm, eng_oe_n, bus_reset;
	logic        dp, dm, dp_oe_n, dm_oe_n, dp_pu, dm_pu, clk_en, low_spd, locked, ev_wr, crc_sup, short_fr;
	logic [31:0] addr;
	logic [15:0] wdata, rdata;
	logic [1:0]  node_state;
	logic [2:0]  thresh;
	logic [4:0]  edge_cur;
	int          miscompares, comparisons, cycles;

	usb_node_ctrl i_dut (.I_REF_CLK(ref_clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_stb),
		.I_RD(rd_stb), .O_RDATA(rdata), .I_DP_LEVEL(dp_lvl), .I_DM_LEVEL(dm_lvl), .I_DIFF_LEVEL(diff_lvl),
		.I_NODE_STATE(node_state), .I_ENG_DP(eng_dp), .I_ENG_DM(eng_dm), .I_ENG_OE_N(eng_oe_n), .O_DP(dp),
		.O_DM(dm), .O_DP_OE_N(dp_oe_n), .O_DM_OE_N(dm_oe_n), .O_DP_PULLUP(dp_pu), .O_DM_PULLUP(dm_pu),
		.O_NODE_CLK_EN(clk_en), .O_LOW_SPEED(low_spd), .O_NODE_LOCKED(locked), .O_EVENT_WR_EN(ev_wr),
		.O_CRC_SUPPRESS(crc_sup), .O_SHORT_FRAME(short_fr), .O_RX_THRESH(thresh), .O_TX_EDGE_CUR(edge_cur));

	usb_hub_model #(.LAG_NS(30)) i_hub (.i_dp(dp), .i_dm(dm), .i_dp_oe_n(dp_oe_n), .i_dm_oe_n(dm_oe_n),
		.i_dp_pullup(dp_pu), .i_dm_pullup(dm_pu), .i_bus_reset(bus_reset), .o_dp_level(dp_lvl),
		.o_dm_level(dm_lvl), .o_diff_level(diff_lvl));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, timeout and shared tasks.
	always #12.5 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			final_report();
		end
	end

	function automatic logic [15:0] pins();
		return {10'h000, dp, dm, dp_oe_n, dm_oe_n, dp_pu, dm_pu};
	endfunction

	function automatic logic [15:0] ctl();
		return {2'h0, clk_en, low_spd, locked, ev_wr, crc_sup, short_fr, thresh, edge_cur};
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask

	task automatic reg_wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr   <= a;
		wdata  <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
		#1;
	endtask

	task automatic reg_rd(input logic [31:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1;
		check(rdata, exp);
	endtask

	task automatic settle();
		repeat (4) @(posedge ref_clk);
		#1;
	endtask

	task final_report();
		if (miscompares == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_reset();
		reg_rd(A_MC, 16'h0000);
		check(ctl(), 16'h0090);
		check(pins(), 16'h0000);
		reg_rd(A_DG, 16'h0000);
		reg_rd(32'h5000_1808, 16'h0000);
	endtask

	task automatic t_enable_gate();
		reg_wr(A_MC, 16'h000A);
		reg_rd(A_MC, 16'h0000);
		reg_wr(A_MC, 16'h0001);
		reg_wr(A_MC, 16'h001F);
		reg_rd(A_MC, 16'h000B);
		check(ctl(), 16'h2C90);
		reg_wr(A_MC, 16'h0000);
		reg_rd(A_MC, 16'h0000);
		check(ctl(), 16'h0090);
		settle();
		check(pins(), 16'h0000);
	endtask

	task automatic t_attach();
		reg_wr(A_MC, 16'h0001);
		settle();
		check(pins(), 16'h0000);
		reg_wr(A_MC, 16'h0009);
		settle();
		check(pins(), 16'h000E);
		@(posedge ref_clk);
		eng_oe_n <= 1'b0;
		eng_dp   <= 1'b1;
		settle();
		check(pins(), 16'h0022);
		@(posedge ref_clk);
		eng_oe_n <= 1'b1;
		eng_dp   <= 1'b0;
		reg_wr(A_TS, 16'h0080);
		reg_wr(A_DG, 16'h0001);
		settle();
		reg_rd(A_DG, 16'h00A1);
		@(posedge ref_clk);
		bus_reset <= 1'b1;
		settle();
		reg_rd(A_DG, 16'h0001);
		@(posedge ref_clk);
		bus_reset <= 1'b0;
		reg_wr(A_MC, 16'h0000);
		reg_wr(A_MC, 16'h0010);
		reg_wr(A_MC, 16'h0011);
		reg_wr(A_MC, 16'h0019);
		settle();
		check(pins(), 16'h000D);
		check(ctl(), 16'h3090);
		reg_wr(A_MC, 16'h0000);
		reg_wr(A_MC, 16'h0000);
		check(ctl(), 16'h0090);
	endtask

	task automatic t_diag();
		reg_wr(A_MC, 16'h0001);
		reg_wr(A_TS, 16'h0080);
		reg_rd(A_TS, 16'h0080);
		reg_rd(A_TR, 16'h0090);
		reg_wr(A_TR, 16'hFF65);
		reg_rd(A_TR, 16'h0065);
		check(ctl(), 16'h2065);
		reg_wr(A_DG, 16'h000B);
		settle();
		check(pins(), 16'h0020);
		reg_rd(A_DG, 16'h00AB);
		reg_wr(A_DG, 16'h000D);
		settle();
		check(pins(), 16'h0010);
		reg_rd(A_DG, 16'h004D);
		reg_wr(A_DG, 16'h000C);
		settle();
		check(pins(), 16'h0000);
		reg_rd(A_DG, 16'h000C);
		reg_wr(A_DG, 16'h0003);
		settle();
		check(pins(), 16'h0000);
		reg_wr(A_TS, 16'h0000);
		settle();
		check(ctl(), 16'h2090);
		reg_rd(A_DG, 16'h0000);
		reg_wr(A_MC, 16'h0000);
	endtask

	task automatic t_test_debug();
		@(posedge ref_clk);
		node_state <= 2'b10;
		reg_wr(A_MC, 16'h0001);
		reg_wr(A_MC, 16'h0003);
		reg_wr(A_TS, 16'h00E0);
		reg_rd(A_TS, 16'h00E0);
		check(ctl(), 16'h2F65);
		reg_wr(A_DG, 16'h0001);
		settle();
		reg_rd(A_DG, 16'h0201);
		reg_wr(A_MC, 16'h0000);
		reg_rd(A_TS, 16'h0000);
		check(ctl(), 16'h0090);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		ref_clk     = 1'b0;
		rst         = 1'b1;
		addr        = 32'h0000_0000;
		wdata       = 16'h0000;
		wr_stb      = 1'b0;
		rd_stb      = 1'b0;
		node_state  = 2'b00;
		eng_dp      = 1'b0;
		eng_dm      = 1'b0;
		eng_oe_n    = 1'b1;
		bus_reset   = 1'b0;
		miscompares = 0;
		comparisons = 0;
		cycles      = 0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		t_reset();
		t_enable_gate();
		t_attach();
		t_diag();
		t_test_debug();
		final_report();
	end

endmodule
